//--- hw/sirq_pkg.sv
package sirq_pkg;

  // ===========================================================
  // register map (printed offsets are indices, byte addr = 4x)
  // ===========================================================
  localparam logic [7:0] SIRQ_IDX_CTRL = 8'h03;
  localparam logic [7:0] SIRQ_IDX_FLAGS = 8'h04;
  localparam logic [7:0] SIRQ_IDX_MGMT = 8'h05;
  localparam logic [7:0] SIRQ_IDX_RING = 8'h07;
  localparam logic [7:0] SIRQ_IDX_PINS = 8'h08;
  localparam int SIRQ_SOCK_STRIDE = 16;

  // ===========================================================
  // reset values
  // ===========================================================
  localparam logic [7:0] SIRQ_CTRL_RST = 8'h00;
  localparam logic [7:0] SIRQ_MGMT_RST = 8'h00;
  localparam logic [3:0] SIRQ_FLAGS_RST = 4'h0;

  // ===========================================================
  // field positions
  // ===========================================================
  localparam int SIRQ_CTRL_ROUTE_LSB = 0;
  localparam int SIRQ_CTRL_REDIR = 4;
  localparam int SIRQ_CTRL_IO = 5;
  localparam int SIRQ_CTRL_RSTDEASSERT = 6;
  localparam int SIRQ_CTRL_RINGSEL = 7;
  localparam int SIRQ_MGMT_ROUTE_LSB = 4;
  localparam int SIRQ_FLAG_BATTDEAD = 0;
  localparam int SIRQ_FLAG_BATTWARN = 1;
  localparam int SIRQ_FLAG_READY = 2;
  localparam int SIRQ_FLAG_DETECT = 3;

  // ===========================================================
  // axi responses
  // ===========================================================
  localparam logic [1:0] SIRQ_RESP_OKAY = 2'b00;
  localparam logic [1:0] SIRQ_RESP_SLVERR = 2'b10;

  // synchronised socket pins of one socket
  typedef struct packed {
    logic ready_or_card_irq_pin;
    logic battery_dead_status_pin;
    logic battery_warning_pin;
    logic insert_detect_1;
    logic insert_detect_2;
  } sirq_pins_t;

endpackage

//--- hw/sirq_socket_irq_status_change.sv
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/100ps
// Functional notes
// RULE_01 - route card irq by 4-bit code
// RULE_02 - redirect bit sends mgmt irq to host_interrupt_line
// RULE_03 - io select chooses memory or io
// RULE_04 - reset-deassert bit sets reset level, ata inverts
// RULE_05 - reset output floats without output enable
// RULE_06 - ring select makes status pin ring
// RULE_07 - ring plus irq15 control drives irq15
// RULE_08 - ring select ignored in memory mode
// RULE_09 - memory mode: battery-dead falling edge sets
// RULE_10 - io mode: any status edge sets
// RULE_11 - io mode detection ignores ring select
// RULE_12 - memory mode: warning falling edge sets
// RULE_13 - ready edge sets; reads zero in io
// RULE_14 - either detect pin change sets
// RULE_15 - flag register read clears flags
// RULE_16 - enable bit gates each flag interrupt
// RULE_17 - upper flag bits zero; resets zero
// RULE_18 - mgmt route uses same code map
// RULE_19 - enable bits ordered dead,warn,ready,detect
// RULE_20 - sync inputs, per-socket copies, set wins
module sirq_socket_irq_status_change #(
  parameter int N_SOCK = 2 // number of sockets
) (
  input wire logic core_clk, // 200 MHz clock
  input wire logic reset_n, // async reset, active low
  input wire logic [11:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [11:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read valid
  input wire logic s_axi_rready, // read ready
  input wire sirq_pkg::sirq_pins_t [N_SOCK-1:0] sock_pins, // socket pins
  input wire logic [N_SOCK-1:0] ata_mode, // socket in ata mode
  input wire logic [N_SOCK-1:0] output_drive_en, // socket output enable
  output logic [N_SOCK-1:0] card_reset_o, // card reset level
  output logic [N_SOCK-1:0] card_reset_oe, // card reset drive enable
  output logic [N_SOCK-1:0] dual_pins_io_mode, // dual pins in io mode
  output logic [15:0] host_irq, // isa irq lines 0..15
  output logic host_interrupt_line // management interrupt line
);
  import sirq_pkg::*;

  // ===========================================================
  // helpers
  // ===========================================================
  // one-hot irq line for a route code; reserved codes give none
  function automatic logic [15:0] irq_decode(input logic [3:0] code);
    logic [15:0] v;
    v = 16'h0000;
    unique case (code)
      4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'ha, 4'hb, 4'hc, 4'he,
      4'hf: v[code] = 1'b1;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  function automatic logic [7:0] idx_of(input logic [11:0] addr);
    return {4'h0, addr[5:2]};
  endfunction

  function automatic int sock_of(input logic [11:0] addr);
    return int'(addr[11:6]);
  endfunction

  // ===========================================================
  // input synchronisers
  // ===========================================================
  sirq_pins_t [N_SOCK-1:0] pin_s1_q;
  sirq_pins_t [N_SOCK-1:0] pin_s2_q;
  sirq_pins_t [N_SOCK-1:0] pin_prev_q;

  // RULE_20 two-flop sync
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_prev_q <= '0;
    end else begin
      pin_s1_q <= sock_pins;
      pin_s2_q <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  // level inputs from outside the clock domain, two flops each
  logic [N_SOCK-1:0] ata_s1_q;
  logic [N_SOCK-1:0] ata_s2_q;
  logic [N_SOCK-1:0] drive_s1_q;
  logic [N_SOCK-1:0] drive_s2_q;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ata_s1_q <= '0;
      ata_s2_q <= '0;
      drive_s1_q <= '0;
      drive_s2_q <= '0;
    end else begin
      ata_s1_q <= ata_mode;
      ata_s2_q <= ata_s1_q;
      drive_s1_q <= output_drive_en;
      drive_s2_q <= drive_s1_q;
    end
  end

  logic [1:0] prime_q;
  // compare only once s1, s2 and prev all hold real samples,
  // so reset values of the pipeline never look like an edge
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prime_q <= 2'h0;
    end else if (prime_q != 2'h3) begin
      prime_q <= prime_q + 2'h1;
    end
  end

  // ===========================================================
  // registers per socket
  // ===========================================================
  logic [N_SOCK-1:0][7:0] ctrl_q;
  logic [N_SOCK-1:0][7:0] mgmt_q;
  logic [N_SOCK-1:0] ring_irq15_q;
  logic [N_SOCK-1:0][3:0] flags_q;

  // ===========================================================
  // axi4-lite slave
  // ===========================================================
  logic aw_full_q;
  logic w_full_q;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_go;
  logic rd_go;

  assign s_axi_awready = !aw_full_q && !bvalid_q;
  assign s_axi_wready = !w_full_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign wr_go = aw_full_q && w_full_q && !bvalid_q;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      w_full_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_go) begin
      w_full_q <= 1'b0;
    end
  end

  logic wr_hit;
  always_comb begin
    wr_hit = (sock_of(aw_addr_q) < N_SOCK) &&
             ((idx_of(aw_addr_q) == SIRQ_IDX_CTRL) ||
              (idx_of(aw_addr_q) == SIRQ_IDX_MGMT) ||
              (idx_of(aw_addr_q) == SIRQ_IDX_RING) ||
              (idx_of(aw_addr_q) == SIRQ_IDX_FLAGS) ||
              (idx_of(aw_addr_q) == SIRQ_IDX_PINS));
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= SIRQ_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? SIRQ_RESP_OKAY : SIRQ_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // register writes; flag and pin words are read only
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= {N_SOCK{SIRQ_CTRL_RST}};
      mgmt_q <= {N_SOCK{SIRQ_MGMT_RST}};
      ring_irq15_q <= '0;
    end else if (wr_go && w_strb_q[0]) begin
      for (int s = 0; s < N_SOCK; s++) begin
        if (sock_of(aw_addr_q) == s) begin
          if (idx_of(aw_addr_q) == SIRQ_IDX_CTRL) begin
            ctrl_q[s] <= w_data_q[7:0];
          end
          if (idx_of(aw_addr_q) == SIRQ_IDX_MGMT) begin
            mgmt_q[s] <= w_data_q[7:0];
          end
          if (idx_of(aw_addr_q) == SIRQ_IDX_RING) begin
            ring_irq15_q[s] <= w_data_q[0];
          end
        end
      end
    end
  end

  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b0;
    for (int s = 0; s < N_SOCK; s++) begin
      if (sock_of(s_axi_araddr) == s) begin
        rd_hit = 1'b1;
        unique case (idx_of(s_axi_araddr))
          SIRQ_IDX_CTRL: rd_mux = {24'h0, ctrl_q[s]};
          // RULE_17 upper bits zero
          // RULE_13 ready change reads zero in io mode
          SIRQ_IDX_FLAGS: rd_mux = {28'h0, flags_q[s] &
            ~{1'b0, ctrl_q[s][SIRQ_CTRL_IO], 2'b00}};
          SIRQ_IDX_MGMT: rd_mux = {24'h0, mgmt_q[s]};
          SIRQ_IDX_RING: rd_mux = {31'h0, ring_irq15_q[s]};
          SIRQ_IDX_PINS: rd_mux = {27'h0, pin_s2_q[s]};
          default: rd_hit = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= SIRQ_RESP_OKAY;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_hit ? SIRQ_RESP_OKAY : SIRQ_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ===========================================================
  // status change detection
  // ===========================================================
  logic [N_SOCK-1:0][3:0] flag_set;
  logic [N_SOCK-1:0] flag_rd;
  always_comb begin
    for (int s = 0; s < N_SOCK; s++) begin
      flag_rd[s] = rd_go && (sock_of(s_axi_araddr) == s) &&
                   (idx_of(s_axi_araddr) == SIRQ_IDX_FLAGS);
      flag_set[s] = 4'h0;
      if (prime_q == 2'h3) begin
        if (ctrl_q[s][SIRQ_CTRL_IO]) begin
          // RULE_10 any edge in io mode
          // RULE_11 ring select not consulted
          flag_set[s][SIRQ_FLAG_BATTDEAD] =
            pin_s2_q[s].battery_dead_status_pin ^
            pin_prev_q[s].battery_dead_status_pin;
        end else begin
          // RULE_09 falling edge battery dead
          flag_set[s][SIRQ_FLAG_BATTDEAD] =
            !pin_s2_q[s].battery_dead_status_pin &&
            pin_prev_q[s].battery_dead_status_pin;
          // RULE_12 falling edge battery warning
          flag_set[s][SIRQ_FLAG_BATTWARN] =
            !pin_s2_q[s].battery_warning_pin &&
            pin_prev_q[s].battery_warning_pin;
          // RULE_13 ready edge, memory mode only
          flag_set[s][SIRQ_FLAG_READY] =
            pin_s2_q[s].ready_or_card_irq_pin ^
            pin_prev_q[s].ready_or_card_irq_pin;
        end
        // RULE_14 either detect pin
        flag_set[s][SIRQ_FLAG_DETECT] =
          (pin_s2_q[s].insert_detect_1 ^ pin_prev_q[s].insert_detect_1) ||
          (pin_s2_q[s].insert_detect_2 ^ pin_prev_q[s].insert_detect_2);
      end
    end
  end

  // RULE_20 per-socket flags, set beats clear
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_q <= {N_SOCK{SIRQ_FLAGS_RST}};
    end else begin
      for (int s = 0; s < N_SOCK; s++) begin
        // RULE_15 read clears
        flags_q[s] <= (flag_rd[s] ? 4'h0 : flags_q[s]) | flag_set[s];
      end
    end
  end

  // ===========================================================
  // outputs
  // ===========================================================
  logic [N_SOCK-1:0] mgmt_req;
  logic [N_SOCK-1:0] ring_on;
  logic [15:0] irq_d;
  logic host_interrupt_line_d;
  always_comb begin
    irq_d = 16'h0000;
    host_interrupt_line_d = 1'b0;
    for (int s = 0; s < N_SOCK; s++) begin
      // RULE_16 enable gating
      // RULE_19 enable bit order matches flags
      mgmt_req[s] = |(flags_q[s] & mgmt_q[s][3:0]);
      // RULE_01 card irq route
      if (ctrl_q[s][SIRQ_CTRL_IO] &&
          !pin_s2_q[s].ready_or_card_irq_pin) begin
        irq_d = irq_d | irq_decode(ctrl_q[s][3:0]);
      end
      // RULE_02 redirect to host_interrupt_line line
      if (mgmt_req[s] && ctrl_q[s][SIRQ_CTRL_REDIR]) begin
        host_interrupt_line_d = 1'b1;
      end else if (mgmt_req[s]) begin
        // RULE_18 same map for mgmt route
        irq_d = irq_d | irq_decode(mgmt_q[s][7:4]);
      end
      // RULE_06 ring role of status pin
      // RULE_08 only in io mode
      // RULE_07 ring drives irq15
      ring_on[s] = ctrl_q[s][SIRQ_CTRL_RINGSEL] &&
                   ctrl_q[s][SIRQ_CTRL_IO] && ring_irq15_q[s];
      if (ring_on[s] && !pin_s2_q[s].battery_dead_status_pin) begin
        irq_d[15] = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      host_irq <= 16'h0000;
      host_interrupt_line <= 1'b0;
      card_reset_o <= '0;
      card_reset_oe <= '0;
      dual_pins_io_mode <= '0;
    end else begin
      host_irq <= irq_d;
      host_interrupt_line <= host_interrupt_line_d;
      for (int s = 0; s < N_SOCK; s++) begin
        // RULE_04 reset level, inverted in ata
        card_reset_o[s] <= !ctrl_q[s][SIRQ_CTRL_RSTDEASSERT] ^ ata_s2_q[s];
        // RULE_05 float without output enable
        card_reset_oe[s] <= drive_s2_q[s];
        // RULE_03 memory or io pin use
        dual_pins_io_mode[s] <= ctrl_q[s][SIRQ_CTRL_IO];
      end
    end
  end

endmodule

//--- tb/sirq_card_model.sv
`timescale 1ns/100ps
module sirq_card_model (
  input wire logic core_clk, // clock
  input wire logic [9:0] flip, // pins to toggle
  output sirq_pkg::sirq_pins_t [1:0] pins // socket pins
);
  import sirq_pkg::*;
  // pins idle high through pull-ups
  initial pins = '1;
  always @(posedge core_clk) pins <= pins ^ flip;
endmodule

//--- tb/sirq_checker_assertions.sv
`timescale 1ns/100ps
module sirq_checker #(
  parameter int N_SOCK = 2 // sockets
) (
  input wire logic core_clk, // clock
  input wire logic reset_n, // reset
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic [11:0] s_axi_araddr, // ar addr
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // r data
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic [N_SOCK-1:0] ata_mode, // ata
  input wire logic [N_SOCK-1:0] output_drive_en, // drive en
  input wire logic [N_SOCK-1:0] card_reset_o, // reset level
  input wire logic [N_SOCK-1:0] card_reset_oe, // reset drive
  input wire logic [N_SOCK-1:0] dual_pins_io_mode // io mode
);
  logic [1:0] up_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // counts edges after reset so past values are valid
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  // ==========================================
  // socket outputs
  a_oe_follows_en: assert property (up_q == 2'h3 |->
    card_reset_oe == $past(output_drive_en, 3)) else $error("oe wrong");
  a_reset_cause: assert property (up_q == 2'h3 &&
    !$stable(card_reset_o) |-> s_axi_bvalid || $past(s_axi_bvalid) ||
    $past(ata_mode, 3) != $past(ata_mode, 4)) else $error("reset moved");
  a_io_mode_cause: assert property (up_q == 2'h3 &&
    !$stable(dual_pins_io_mode) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("io mode moved");
  // ==========================================
  // register bus
  a_flags_upper_zero: assert property (s_axi_arvalid &&
    s_axi_arready && s_axi_araddr[5:0] == 6'h10 |=>
    s_axi_rdata[31:4] == 28'h0) else $error("upper flags set");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("no read answer");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("no bresp");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("bresp dropped");
  a_busy_refuses: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken busy");
  a_read_refuses: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken busy");
endmodule
bind sirq_socket_irq_status_change sirq_checker #(.N_SOCK(N_SOCK)) u_chk (.*);

//--- tb/tb.sv
`timescale 1ns/100ps
module tb;
  import sirq_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, host_interrupt_line;
  logic [1:0] s_axi_bresp, s_axi_rresp, card_reset_o, card_reset_oe;
  logic [1:0] ata_mode = 2'h0, output_drive_en = 2'h3, dual_pins_io_mode;
  logic [15:0] host_irq;
  logic [9:0] flip = 10'h0;
  sirq_pins_t [1:0] sock_pins;
  logic [33:0] exp_q[$];
  logic [31:0] seed = 32'h9ef36126;
  int fail_count = 0;
  int check_count = 0;

  sirq_socket_irq_status_change #(.N_SOCK(2)) uut (.*);
  sirq_card_model card (.core_clk(core_clk), .flip(flip), .pins(sock_pins));

  initial forever #2.5 core_clk = ~core_clk;

  // ==========================================
  // helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // route codes equal the irq number they select
  function automatic logic [15:0] irq_of(input logic [3:0] c);
    case (c)
      4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'ha, 4'hb, 4'hc, 4'he, 4'hf: irq_of = 16'h1 << c;
      default: irq_of = 16'h0;
    endcase
  endfunction
  task automatic close_out();
    if (fail_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input int s, input logic [7:0] i, input logic [7:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= 12'(s * 64) + {2'h0, i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input int s, input logic [7:0] i, input logic [7:0] d,
                    input logic [1:0] r = SIRQ_RESP_OKAY);
    @(posedge core_clk);
    exp_q.push_back({r, 24'h0, d});
    s_axi_araddr <= 12'(s * 64) + {2'h0, i, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  task automatic pin(input int s, input int b);
    @(posedge core_clk);
    flip <= 10'h1 << (s * 5 + b);
    @(posedge core_clk);
    flip <= 10'h0;
    repeat (6) @(posedge core_clk);
  endtask

  // read results are compared in order of request
  always @(posedge core_clk) begin
    if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0)
      chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
  end

  initial begin
    #100000;
    fail_count++;
    close_out();
  end

  // ==========================================
  // main sequence
  initial begin
    logic [31:0] v;
    logic [4:0] c;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(0, SIRQ_IDX_CTRL, 8'h00);
    rd(0, SIRQ_IDX_FLAGS, 8'h00);
    rd(0, SIRQ_IDX_MGMT, 8'h00);
    rd(0, 8'h0f, 8'h00, SIRQ_RESP_SLVERR);
    for (int k = 0; k < 3; k++) begin
      v = xs();
      wr(1, SIRQ_IDX_CTRL, v[7:0]);
      rd(1, SIRQ_IDX_CTRL, v[7:0]);
      rd(0, SIRQ_IDX_CTRL, 8'h00);
    end
    // memory mode edges: falls set, rises of battery pins do not
    pin(0, 3);
    pin(0, 2);
    pin(0, 4);
    pin(0, 0);
    rd(0, SIRQ_IDX_FLAGS, 8'h0f);
    rd(0, SIRQ_IDX_FLAGS, 8'h00);
    pin(0, 3);
    pin(0, 2);
    rd(0, SIRQ_IDX_FLAGS, 8'h00);
    pin(0, 4);
    rd(0, SIRQ_IDX_FLAGS, 8'h04);
    // management routing with a pending detect flag
    pin(0, 1);
    for (c = 0; c < 16; c++) begin
      wr(0, SIRQ_IDX_MGMT, {c[3:0], 4'h8});
      repeat (2) @(posedge core_clk);
      chk(34'({host_irq, host_interrupt_line}), 34'({irq_of(c[3:0]), 1'b0}));
    end
    wr(0, SIRQ_IDX_MGMT, 8'hf7);
    repeat (2) @(posedge core_clk);
    chk(34'(host_irq), 34'h0);
    wr(0, SIRQ_IDX_MGMT, 8'hf8);
    wr(0, SIRQ_IDX_CTRL, 8'h10);
    repeat (2) @(posedge core_clk);
    chk(34'({host_irq, host_interrupt_line}), 34'h1);
    rd(0, SIRQ_IDX_FLAGS, 8'h08);
    repeat (2) @(posedge core_clk);
    chk(34'(host_interrupt_line), 34'h0);
    wr(0, SIRQ_IDX_MGMT, 8'h00);
    // io mode with ring select: any status edge sets, ready reads zero
    wr(0, SIRQ_IDX_CTRL, 8'ha0);
    repeat (2) @(posedge core_clk);
    chk(34'(dual_pins_io_mode[0]), 34'h1);
    pin(0, 3);
    rd(0, SIRQ_IDX_FLAGS, 8'h01);
    pin(0, 3);
    rd(0, SIRQ_IDX_FLAGS, 8'h01);
    pin(0, 4);
    rd(0, SIRQ_IDX_FLAGS, 8'h00);
    for (c = 0; c < 16; c++) begin
      wr(0, SIRQ_IDX_CTRL, {4'h2, c[3:0]});
      repeat (2) @(posedge core_clk);
      chk(34'(host_irq), 34'(irq_of(c[3:0])));
    end
    pin(0, 4);
    // ring indicate onto irq15
    wr(0, SIRQ_IDX_RING, 8'h01);
    pin(0, 3);
    wr(0, SIRQ_IDX_CTRL, 8'ha0);
    repeat (2) @(posedge core_clk);
    chk(34'(host_irq), 34'h8000);
    wr(0, SIRQ_IDX_CTRL, 8'h80);
    repeat (2) @(posedge core_clk);
    chk(34'(host_irq), 34'h0);
    wr(0, SIRQ_IDX_CTRL, 8'h20);
    repeat (2) @(posedge core_clk);
    chk(34'(host_irq), 34'h0);
    pin(0, 3);
    // card reset level and drive enable
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk);
      ata_mode <= {1'b0, k[1]};
      wr(0, SIRQ_IDX_CTRL, {1'b0, k[0], 6'h0});
      repeat (2) @(posedge core_clk);
      chk(34'({card_reset_o[0], card_reset_oe[0]}), 34'({~k[0] ^ k[1], 1'b1}));
    end
    @(posedge core_clk);
    output_drive_en <= 2'h2;
    repeat (4) @(posedge core_clk);
    chk(34'(card_reset_oe), 34'h2);
    close_out();
  end
endmodule
